// File: interrupt_vector_and_flags.sv
// Interrupt request mapping, flag status registers and AXI4-Lite slave
//
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`default_nettype none

// How it works
// - Vector number equals request number plus eight
// - Primary table entry at twice vector plus four
// - Alternate table entry sits 0x100 above primary
// - First UART error raises request 65
// - CAN transmit request raises request 70
// - Secondary special event raises request 73
// - Second quadrature compare raises request 75
// - Converter pairs 8-12 raise requests 81-85
// - PWM generators 1-9 raise requests 94-102
// - Comparators 2-4 raise requests 103-105
// - Converter pairs 0-7 raise requests 110-117
// - Reserved vectors have no source connected
// - Flag one upper byte holds eight sources
// - Flag one bits 7-5 zero, 4-0 sources
// - Flag two bits 15-7 zero, 6-0 sources
// - No CAN controller: CAN sources disabled

module interrupt_vector_and_flags
    import irq_map_pkg::*;
#(
    parameter bit HAS_CAN = 1'b1
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire irq_map_pkg::axil_req_t bus_req,
    output irq_map_pkg::axil_rsp_t bus_rsp,
    // Request sources
    input wire irq_map_pkg::flag_one_src_t flag_one_src,
    input wire irq_map_pkg::flag_two_src_t flag_two_src,
    input wire irq_map_pkg::vec_src_t vec_src,
    // Dispatch of the highest-priority pending request
    output logic dispatch_valid,
    output logic [6:0] dispatch_request,
    output logic [6:0] dispatch_vector,
    output logic [23:0] dispatch_address
);

    import irq_map_pkg::*;

    top_state_t q;
    top_state_t d;

    logic [15:0] flag_one_q;
    logic [15:0] flag_two_q;
    logic [REQ_COUNT-1:0] pend_q;
    logic [15:0] flag_one_set;
    logic [15:0] flag_two_set;
    logic [REQ_COUNT-1:0] pend_set;
    logic [15:0] flag_one_wdata;
    logic [15:0] flag_two_wdata;
    logic [REQ_COUNT-1:0] pend_wdata;
    logic flag_one_wr;
    logic flag_two_wr;
    logic ack_wr;
    logic wr_fire;
    logic sel_found;
    logic [6:0] sel_req;
    logic [6:0] sel_vec;
    logic [23:0] sel_primary;
    logic [23:0] sel_addr;

    ////////////////////////////////////////////////////////////////////////
    // Flag set vectors from the sources
    always_comb begin
        flag_one_set = {flag_one_src[12:5], 3'h0, flag_one_src[4:0]};
        flag_two_set = {9'h000, flag_two_src};
        if (!HAS_CAN) begin
            flag_two_set[CAN_EVENT_BIT] = 1'b0;
            flag_two_set[CAN_RECEIVE_BIT] = 1'b0;
        end
    end

    // Pending set vector; reserved request numbers stay zero
    always_comb begin
        pend_set = '0;
        pend_set[REQ_PRIMARY_SPECIAL] = vec_src.primary_special_event;
        pend_set[REQ_QEI_ONE_COMPARE] = vec_src.qei_one_compare;
        pend_set[REQ_UART_ONE_ERROR] = vec_src.uart_one_error;
        pend_set[REQ_UART_TWO_ERROR] = vec_src.uart_two_error;
        pend_set[REQ_CAN_TRANSMIT] = vec_src.can_transmit_request
            & HAS_CAN;
        pend_set[REQ_SECONDARY_SPECIAL] =
            vec_src.secondary_special_event;
        pend_set[REQ_QEI_TWO_COMPARE] = vec_src.qei_two_compare;
        for (int i = 0; i < 5; i++) begin
            pend_set[REQ_ADC_HI_BASE + i] = vec_src.adc_pair_hi_done[i];
        end
        for (int i = 0; i < 9; i++) begin
            pend_set[REQ_PWM_BASE + i] = vec_src.pwm_gen_event[i];
        end
        for (int i = 0; i < 3; i++) begin
            pend_set[REQ_CMP_BASE + i] = vec_src.comparator_event[i];
        end
        for (int i = 0; i < 8; i++) begin
            pend_set[REQ_ADC_LO_BASE + i] = vec_src.adc_pair_lo_done[i];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lowest pending request number has the highest natural priority
    always_comb begin
        sel_found = 1'b0;
        sel_req = 7'h00;
        for (int i = REQ_COUNT - 1; i >= 0; i--) begin
            if (pend_q[i]) begin
                sel_found = 1'b1;
                sel_req = 7'(i);
            end
        end
    end

    // Vector number and table entry addresses
    always_comb begin
        sel_vec = sel_req + VECTOR_OFFSET;
        sel_primary = {16'h0000, sel_vec, 1'b0} + IVT_BASE;
        if (q.alt_sel) begin
            sel_addr = sel_primary + ALT_OFFSET;
        end else begin
            sel_addr = sel_primary;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write strobes and data with byte lanes merged over the current value
    always_comb begin
        wr_fire = q.aw_have & q.w_have & ~q.bvalid;
        flag_one_wr = wr_fire & (q.aw_addr == ADDR_FLAG_ONE);
        flag_two_wr = wr_fire & (q.aw_addr == ADDR_FLAG_TWO);
        ack_wr = wr_fire & (q.aw_addr == ADDR_ACK) & q.w_strb[0]
            & q.w_data[0] & q.disp_valid;
        flag_one_wdata = flag_one_q;
        flag_two_wdata = flag_two_q;
        if (q.w_strb[0]) begin
            flag_one_wdata[7:0] = q.w_data[7:0];
            flag_two_wdata[7:0] = q.w_data[7:0];
        end
        if (q.w_strb[1]) begin
            flag_one_wdata[15:8] = q.w_data[15:8];
            flag_two_wdata[15:8] = q.w_data[15:8];
        end
        pend_wdata = pend_q;
        pend_wdata[q.disp_req] = 1'b0;
    end

    // Flag status registers and the pending set
    flag_bank #(
        .WIDTH(16),
        .MASK(FLAG_ONE_MASK)
    ) u_flag_one (
        .aclk(aclk),
        .aresetn(aresetn),
        .wr_en(flag_one_wr),
        .wr_data(flag_one_wdata),
        .set(flag_one_set),
        .bits(flag_one_q)
    );

    flag_bank #(
        .WIDTH(16),
        .MASK(FLAG_TWO_MASK)
    ) u_flag_two (
        .aclk(aclk),
        .aresetn(aresetn),
        .wr_en(flag_two_wr),
        .wr_data(flag_two_wdata),
        .set(flag_two_set),
        .bits(flag_two_q)
    );

    flag_bank #(
        .WIDTH(REQ_COUNT),
        .MASK('1)
    ) u_pending (
        .aclk(aclk),
        .aresetn(aresetn),
        .wr_en(ack_wr),
        .wr_data(pend_wdata),
        .set(pend_set),
        .bits(pend_q)
    );

    ////////////////////////////////////////////////////////////////////////
    // Bus slave and dispatch registers
    always_comb begin
        d = q;
        // Write address and data are taken independently
        if (bus_req.awvalid && !q.aw_have && !q.bvalid) begin
            d.aw_addr = bus_req.awaddr;
            d.aw_have = 1'b1;
        end
        if (bus_req.wvalid && !q.w_have && !q.bvalid) begin
            d.w_data = bus_req.wdata;
            d.w_strb = bus_req.wstrb;
            d.w_have = 1'b1;
        end
        // Write takes effect once both halves are held
        if (wr_fire) begin
            d.aw_have = 1'b0;
            d.w_have = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = RESP_OKAY;
            case (q.aw_addr)
                ADDR_FLAG_ONE, ADDR_FLAG_TWO, ADDR_ACK,
                ADDR_VEC_STATUS, ADDR_VEC_ADDRESS: begin
                    d.bresp = RESP_OKAY;
                end
                ADDR_CONTROL: begin
                    if (q.w_strb[0]) begin
                        d.alt_sel = q.w_data[0];
                    end
                end
                default: begin
                    d.bresp = RESP_SLVERR;
                end
            endcase
        end else if (q.bvalid && bus_req.bready) begin
            d.bvalid = 1'b0;
        end
        // Read answered one cycle after the address is taken
        if (q.rvalid) begin
            if (bus_req.rready) begin
                d.rvalid = 1'b0;
            end
        end else if (bus_req.arvalid) begin
            d.rvalid = 1'b1;
            d.rresp = RESP_OKAY;
            d.rdata = 32'h0000_0000;
            case (bus_req.araddr)
                ADDR_FLAG_ONE: begin
                    d.rdata = {16'h0000, flag_one_q};
                end
                ADDR_FLAG_TWO: begin
                    d.rdata = {16'h0000, flag_two_q};
                end
                ADDR_VEC_STATUS: begin
                    d.rdata[STATUS_VALID_BIT] = q.disp_valid;
                    d.rdata[STATUS_REQ_LSB +: 7] = q.disp_req;
                    d.rdata[6:0] = q.disp_vec;
                end
                ADDR_VEC_ADDRESS: begin
                    d.rdata = {8'h00, q.disp_addr};
                end
                ADDR_CONTROL: begin
                    d.rdata[0] = q.alt_sel;
                end
                ADDR_ACK: begin
                    d.rdata = 32'h0000_0000;
                end
                default: begin
                    d.rresp = RESP_SLVERR;
                end
            endcase
        end
        // Dispatch outputs follow the priority choice one cycle later
        d.disp_valid = sel_found;
        d.disp_req = sel_found ? sel_req : 7'h00;
        d.disp_vec = sel_found ? sel_vec : 7'h00;
        d.disp_addr = sel_found ? sel_addr : 24'h00_0000;
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    always_comb begin
        bus_rsp.awready = ~q.aw_have & ~q.bvalid;
        bus_rsp.wready = ~q.w_have & ~q.bvalid;
        bus_rsp.bvalid = q.bvalid;
        bus_rsp.bresp = q.bresp;
        bus_rsp.arready = ~q.rvalid;
        bus_rsp.rvalid = q.rvalid;
        bus_rsp.rdata = q.rdata;
        bus_rsp.rresp = q.rresp;
    end

    assign dispatch_valid = q.disp_valid;
    assign dispatch_request = q.disp_req;
    assign dispatch_vector = q.disp_vec;
    assign dispatch_address = q.disp_addr;

endmodule

`default_nettype wire

// File: irq_map_pkg.sv
// Shared constants, register map and carrier types for the interrupt map
`default_nettype none

package irq_map_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Request and vector numbering
    localparam int unsigned REQ_W = 7;
    localparam int unsigned REQ_COUNT = 128;
    localparam logic [6:0] VECTOR_OFFSET = 7'h08;
    localparam logic [23:0] IVT_BASE = 24'h00_0004;
    localparam logic [23:0] ALT_OFFSET = 24'h00_0100;

    // Request numbers of the mapped sources
    localparam int unsigned REQ_PRIMARY_SPECIAL = 57;
    localparam int unsigned REQ_QEI_ONE_COMPARE = 58;
    localparam int unsigned REQ_UART_ONE_ERROR = 65;
    localparam int unsigned REQ_UART_TWO_ERROR = 66;
    localparam int unsigned REQ_CAN_TRANSMIT = 70;
    localparam int unsigned REQ_SECONDARY_SPECIAL = 73;
    localparam int unsigned REQ_QEI_TWO_COMPARE = 75;
    localparam int unsigned REQ_ADC_HI_BASE = 81;
    localparam int unsigned REQ_PWM_BASE = 94;
    localparam int unsigned REQ_CMP_BASE = 103;
    localparam int unsigned REQ_ADC_LO_BASE = 110;

    ////////////////////////////////////////////////////////////////////////
    // Register byte addresses
    localparam logic [31:0] ADDR_FLAG_ONE = 32'h0000_0000;
    localparam logic [31:0] ADDR_FLAG_TWO = 32'h0000_0004;
    localparam logic [31:0] ADDR_VEC_STATUS = 32'h0000_0008;
    localparam logic [31:0] ADDR_VEC_ADDRESS = 32'h0000_000C;
    localparam logic [31:0] ADDR_CONTROL = 32'h0000_0010;
    localparam logic [31:0] ADDR_ACK = 32'h0000_0014;

    // Implemented bits and reset values
    localparam logic [15:0] FLAG_ONE_MASK = 16'hFF1F;
    localparam logic [15:0] FLAG_TWO_MASK = 16'h007F;
    localparam logic [15:0] FLAG_RESET = 16'h0000;
    localparam int unsigned CAN_EVENT_BIT = 3;
    localparam int unsigned CAN_RECEIVE_BIT = 2;
    localparam int unsigned STATUS_VALID_BIT = 31;
    localparam int unsigned STATUS_REQ_LSB = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // Bus carrier
    typedef struct packed {
        logic [31:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [31:0] araddr;
        logic arvalid;
        logic rready;
    } axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } axil_rsp_t;

    // Flag sources, most significant first
    typedef struct packed {
        logic uart_two_tx_flag;
        logic uart_two_rx_flag;
        logic pin_two_flag;
        logic timer_five_flag;
        logic timer_four_flag;
        logic compare_four_flag;
        logic compare_three_flag;
        logic dma_two_done_flag;
        logic pin_one_flag;
        logic change_notify_flag;
        logic comparator_one_flag;
        logic i2c_master_flag;
        logic i2c_slave_flag;
    } flag_one_src_t;

    typedef struct packed {
        logic capture_four_flag;
        logic capture_three_flag;
        logic dma_three_done_flag;
        logic can_event_flag;
        logic can_receive_flag;
        logic spi_two_event_flag;
        logic spi_two_error_flag;
    } flag_two_src_t;

    // Vectored sources
    typedef struct packed {
        logic primary_special_event;
        logic qei_one_compare;
        logic uart_one_error;
        logic uart_two_error;
        logic can_transmit_request;
        logic secondary_special_event;
        logic qei_two_compare;
        logic [4:0] adc_pair_hi_done;
        logic [8:0] pwm_gen_event;
        logic [2:0] comparator_event;
        logic [7:0] adc_pair_lo_done;
    } vec_src_t;

    // Top-level state
    typedef struct packed {
        logic [31:0] aw_addr;
        logic aw_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic w_have;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic alt_sel;
        logic disp_valid;
        logic [6:0] disp_req;
        logic [6:0] disp_vec;
        logic [23:0] disp_addr;
    } top_state_t;

endpackage

`default_nettype wire

// File: flag_bank.sv
// Bank of sticky flags: hardware sets, software writes, set wins
`default_nettype none

module flag_bank #(
    parameter int WIDTH = 16,
    parameter logic [WIDTH-1:0] MASK = '1
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Software write
    input wire logic wr_en,
    input wire logic [WIDTH-1:0] wr_data,
    // Hardware set and flag state
    input wire logic [WIDTH-1:0] set,
    output logic [WIDTH-1:0] bits
);

    typedef struct packed {
        logic [WIDTH-1:0] flags;
    } bank_state_t;

    bank_state_t state_q;
    bank_state_t state_d;

    ////////////////////////////////////////////////////////////////////////
    // Write replaces the flags, then any event in the same cycle is ORed in
    always_comb begin
        state_d = state_q;
        if (wr_en) begin
            state_d.flags = wr_data;
        end
        state_d.flags = (state_d.flags | set) & MASK;
    end

    // Flags clear on reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign bits = state_q.flags;

endmodule

`default_nettype wire

// File: irq_src_model.sv
// Request source model and the expected request map
`default_nettype none

package irq_rules_pkg;
    // Request number raised by bit i of the vectored source word
    function automatic logic [6:0] req_of(int i);
        if (i < 8) return 7'h6E + 7'(i);
        if (i < 11) return 7'h5F + 7'(i);
        if (i < 20) return 7'h53 + 7'(i);
        if (i < 25) return 7'h3D + 7'(i);
        case (i)
            25: return 7'h4B;
            26: return 7'h49;
            27: return 7'h46;
            28: return 7'h42;
            29: return 7'h41;
            30: return 7'h3A;
            default: return 7'h39;
        endcase
    endfunction
    // Lowest request number among the raised sources
    function automatic logic [6:0] low_req(logic [31:0] v);
        logic [6:0] r;
        r = 7'h7F;
        for (int i = 0; i < 32; i++) begin
            if (v[i] && req_of(i) < r) r = req_of(i);
        end
        return r;
    endfunction
endpackage

module irq_src_model
    import irq_map_pkg::*;
(
    // Clock
    input wire logic aclk,
    // Commands from the bench
    input wire logic fire,
    input wire irq_map_pkg::vec_src_t vec_cmd,
    input wire irq_map_pkg::flag_one_src_t one_cmd,
    input wire irq_map_pkg::flag_two_src_t two_cmd,
    // Request lines into the block
    output var irq_map_pkg::vec_src_t vec_src,
    output var irq_map_pkg::flag_one_src_t one_src,
    output var irq_map_pkg::flag_two_src_t two_src
);
    timeunit 1ns;
    timeprecision 1ps;
    // Lines stay raised while fire is held and drop together after it
    always_ff @(posedge aclk) begin
        vec_src <= fire ? vec_cmd : '0;
        one_src <= fire ? one_cmd : '0;
        two_src <= fire ? two_cmd : '0;
    end
endmodule

`default_nettype wire

// File: interrupt_vector_and_flags_asserts.sv
// Port checks of the interrupt map block
`default_nettype none

module irq_map_check
    import irq_map_pkg::*;
    import irq_rules_pkg::*;
#(
    parameter bit HAS_CAN = 1'b1
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus and sources
    input wire irq_map_pkg::axil_req_t bus_req,
    input wire irq_map_pkg::axil_rsp_t bus_rsp,
    input wire irq_map_pkg::vec_src_t vec_src,
    // Dispatch
    input wire logic dispatch_valid,
    input wire logic [6:0] dispatch_request,
    input wire logic [6:0] dispatch_vector,
    input wire logic [23:0] dispatch_address
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Source word as the block acts on it: CAN transmit gated when absent
    localparam logic [31:0] CAN_GATE = HAS_CAN ? 32'hFFFF_FFFF : 32'hF7FF_FFFF;
    logic [31:0] live_src;
    assign live_src = vec_src & CAN_GATE;

    vector_offset_a: assert property (dispatch_valid |->
        dispatch_vector == dispatch_request + 7'h08)
        else $error("vector is not request plus eight");
    primary_entry_a: assert property (dispatch_valid |->
        dispatch_address[7:0] == {dispatch_vector, 1'b0} + 8'h04)
        else $error("table entry not twice vector plus four");
    alt_entry_a: assert property (dispatch_valid |->
        dispatch_address[23:9] == 15'h0000)
        else $error("table entry beyond alternate table");
    mapped_only_a: assert property (dispatch_valid |->
        dispatch_request inside {7'h39, 7'h3A, 7'h41, 7'h42, 7'h46,
        7'h49, 7'h4B, [7'h51:7'h55], [7'h5E:7'h69], [7'h6E:7'h75]})
        else $error("reserved request dispatched");
    source_map_a: assert property (
        !dispatch_valid && $past(live_src) == '0 && live_src != '0
        ##1 live_src == '0 |-> ##1 dispatch_valid &&
        dispatch_request == low_req($past(live_src, 2)))
        else $error("source raised the wrong request");
    write_answer_a: assert property (bus_req.awvalid &&
        bus_rsp.awready && bus_req.wvalid && bus_rsp.wready
        |=> !bus_rsp.bvalid ##1 bus_rsp.bvalid)
        else $error("write answer not two cycles after take");
    read_answer_a: assert property (bus_req.arvalid &&
        bus_rsp.arready |=> bus_rsp.rvalid ##1 !bus_rsp.rvalid)
        else $error("read answer mistimed");
    busy_refuse_a: assert property (bus_rsp.bvalid ||
        bus_rsp.rvalid |-> !(bus_rsp.awready && bus_rsp.bvalid) &&
        !(bus_rsp.arready && bus_rsp.rvalid))
        else $error("request taken while answer pending");
    unmapped_read_a: assert property (bus_req.arvalid &&
        bus_rsp.arready && bus_req.araddr > ADDR_ACK |=>
        bus_rsp.rresp == RESP_SLVERR && bus_rsp.rdata == 32'h0000_0000)
        else $error("unmapped read not refused");
endmodule

bind interrupt_vector_and_flags irq_map_check #(.HAS_CAN(HAS_CAN)) i_check (
    .aclk(aclk), .aresetn(aresetn), .bus_req(bus_req),
    .bus_rsp(bus_rsp), .vec_src(vec_src),
    .dispatch_valid(dispatch_valid), .dispatch_request(dispatch_request),
    .dispatch_vector(dispatch_vector), .dispatch_address(dispatch_address)
);

`default_nettype wire

// File: interrupt_vector_and_flags_test.sv
// Self-checking bench for the interrupt map and flag registers
`default_nettype none

module interrupt_vector_and_flags_test;
    import irq_map_pkg::*;
    import irq_rules_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic aclk;
    logic aresetn;
    logic fire;
    axil_req_t req;
    axil_rsp_t rsp;
    flag_one_src_t one_src, one_cmd;
    flag_two_src_t two_src, two_cmd;
    vec_src_t vec_src, vec_cmd;
    logic disp_v;
    logic [6:0] disp_r, disp_n;
    logic [23:0] disp_a;
    int error_cnt;
    int checked;
    logic [33:0] exp_q[$];
    string name_q[$];
    logic [1:0] bexp_q[$];
    logic nc_v;

    interrupt_vector_and_flags i_dut (
        .aclk(aclk), .aresetn(aresetn), .bus_req(req), .bus_rsp(rsp),
        .flag_one_src(one_src), .flag_two_src(two_src), .vec_src(vec_src),
        .dispatch_valid(disp_v), .dispatch_request(disp_r),
        .dispatch_vector(disp_n), .dispatch_address(disp_a)
    );
    irq_src_model i_src (
        .aclk(aclk), .fire(fire), .vec_cmd(vec_cmd), .one_cmd(one_cmd),
        .two_cmd(two_cmd), .vec_src(vec_src), .one_src(one_src),
        .two_src(two_src)
    );
    // Variant without the CAN controller; only its dispatch is watched
    interrupt_vector_and_flags #(.HAS_CAN(1'b0)) i_dut_nocan (
        .aclk(aclk), .aresetn(aresetn), .bus_req('0), .bus_rsp(),
        .flag_one_src(one_src), .flag_two_src(two_src), .vec_src(vec_src),
        .dispatch_valid(nc_v), .dispatch_request(),
        .dispatch_vector(), .dispatch_address()
    );

    ////////////////////////////////////////////////////////////////////////
    // Clock
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    task automatic chk(string what, logic [39:0] seen, logic [39:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Write one word; each channel released at the edge that takes it
    task automatic wr(logic [31:0] a, logic [31:0] d);
        logic ta, tw, tb;
        bexp_q.push_back(a > ADDR_ACK ? RESP_SLVERR : RESP_OKAY);
        req.awaddr <= a;
        req.wdata <= d;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(negedge aclk);
            ta = rsp.awready;
            tw = rsp.wready;
            tb = rsp.bvalid;
            @(posedge aclk);
            if (ta) req.awvalid <= 1'b0;
            if (tw) req.wvalid <= 1'b0;
            if (tb) break;
        end
    endtask

    // Read one word and note the expected answer
    task automatic rd(logic [31:0] a, logic [33:0] e, string what);
        logic ta, tv;
        exp_q.push_back(e);
        name_q.push_back(what);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(negedge aclk);
            ta = rsp.arready;
            tv = rsp.rvalid;
            @(posedge aclk);
            if (ta) req.arvalid <= 1'b0;
            if (tv) break;
        end
    endtask

    task automatic pulse(vec_src_t v, flag_one_src_t a, flag_two_src_t b);
        vec_cmd <= v;
        one_cmd <= a;
        two_cmd <= b;
        fire <= 1'b1;
        @(posedge aclk);
        fire <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask

    // Wait for dispatch, compare, then acknowledge it
    task automatic serve(logic [6:0] r, int alt, logic [7:0] nx);
        logic [23:0] a;
        logic [6:0] n;
        n = r + 7'h08;
        a = {16'h0000, n, 1'b0} + 24'h00_0004;
        if (alt != 0) a = a + 24'h00_0100;
        @(negedge aclk);
        for (int k = 0; k < 20 && disp_v !== 1'b1; k++) @(negedge aclk);
        chk("dispatch", {disp_r, disp_n, disp_a}, {r, n, a});
        @(posedge aclk);
        wr(ADDR_ACK, 32'h0000_0001);
        @(negedge aclk);
        chk("acked", {disp_v, disp_r}, nx);
        @(posedge aclk);
    endtask

    // Compare each read and write answer with the oldest note
    always @(negedge aclk) begin
        if (rsp.rvalid === 1'b1 && req.rready === 1'b1) begin
            chk(name_q.pop_front(), {rsp.rresp, rsp.rdata},
                exp_q.pop_front());
        end
        if (rsp.bvalid === 1'b1 && req.bready === 1'b1) begin
            chk("bresp", rsp.bresp, bexp_q.pop_front());
        end
    end

    // Watchdog
    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        $display("[FAIL] watchdog expected end seen hang");
        report_and_stop();
    end

    // Main sequence
    initial begin
        logic [31:0] v;
        logic [6:0] r;
        logic [12:0] p1;
        logic [6:0] p2;
        logic [7:0] nx;
        error_cnt = 0;
        checked = 0;
        aresetn = 1'b0;
        fire = 1'b0;
        vec_cmd = '0;
        one_cmd = '0;
        two_cmd = '0;
        req = '0;
        req.wstrb = 4'hF;
        req.bready = 1'b1;
        req.rready = 1'b1;
        v = $urandom(86);
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        wr(32'h0000_0020, 32'hFFFF_FFFF);
        rd(ADDR_FLAG_ONE, 34'h0_0000_0000, "flag one reset");
        rd(ADDR_FLAG_TWO, 34'h0_0000_0000, "flag two reset");
        rd(32'h0000_0020, {RESP_SLVERR, 32'h0000_0000}, "unmapped");
        $display("reset test done");
        p1 = 13'($urandom);
        p2 = 7'($urandom);
        pulse('0, p1, p2);
        rd(ADDR_FLAG_ONE, {18'h0, p1[12:5], 3'h0, p1[4:0]}, "one");
        rd(ADDR_FLAG_TWO, {27'h000_0000, p2}, "two");
        one_cmd <= 13'h1FFF;
        fire <= 1'b1;
        @(posedge aclk);
        wr(ADDR_FLAG_ONE, 32'h0000_0000);
        fire <= 1'b0;
        repeat (2) @(posedge aclk);
        rd(ADDR_FLAG_ONE, 34'h0_0000_FF1F, "set beats clear");
        wr(ADDR_FLAG_ONE, 32'h0000_0000);
        rd(ADDR_FLAG_ONE, 34'h0_0000_0000, "cleared");
        wr(ADDR_FLAG_ONE, 32'hFFFF_FFFF);
        wr(ADDR_FLAG_TWO, 32'hFFFF_FFFF);
        rd(ADDR_FLAG_ONE, 34'h0_0000_FF1F, "one spare");
        rd(ADDR_FLAG_TWO, 34'h0_0000_007F, "two spare");
        pulse(32'h0800_0000, '0, '0);
        serve(req_of(27), 0, 8'h00);
        chk("no can", nc_v, 1'b0);
        $display("flag test done");
        for (int alt = 0; alt < 2; alt++) begin
            wr(ADDR_CONTROL, 32'(alt));
            for (int i = 0; i < 32; i++) begin
                pulse(32'h0000_0001 << i, '0, '0);
                serve(req_of(i), alt, 8'h00);
            end
        end
        $display("vector test done");
        v = $urandom | 32'h8000_0001;
        pulse(v, '0, '0);
        repeat ($countones(v)) begin
            r = low_req(v);
            for (int i = 0; i < 32; i++) if (req_of(i) == r) v[i] = 1'b0;
            nx = (v == 0) ? 8'h00 : {1'b1, low_req(v)};
            serve(r, 1, nx);
        end
        chk("reads left", exp_q.size(), 0);
        $display("priority test done");
        report_and_stop();
    end
endmodule

`default_nettype wire
